// file: vms_misc_seq_regs.v
// Misc output, status, video enable and sequencer register bank with reset sequencing
// Operation
// RULE1: Revision code register read-only, fixed value
// RULE2: Misc output bit 1 is plain storage
// RULE3: Clock select bit 0 picks clock input
// RULE4: LCD-only display forces alternate clock input
// RULE5: Inactive clock oscillator disabled automatically
// RULE6: Status register 0 bit 7 vertical interrupt
// RULE7: Video enable register, bit 0 only
// RULE8: Either sequencer reset bit halts sequencer
// RULE9: Panel power removed before sequencer halts
// RULE10: In-progress memory access finishes before halt
// RULE11: New access pends, ready low during reset
// RULE12: Clocking mode bits 4,2,1 plain storage
// RULE13: Character width bit ignored in LCD mode
// RULE14: Display enable bit0 LCD, bit1 CRT
// RULE15: Three-bit index selects sequencer data register
// RULE16: Clearing reset resumes, serves pending, releases ready
`timescale 1ns/10ps
`include "vms_regs.vh"
module vms_misc_seq_regs (
	input  wire       i_clock,        // 20 MHz system clock
	input  wire       i_nrst,         // Async reset, active low
	input  wire [9:0] i_io_addr,      // Host I/O address
	input  wire [7:0] i_io_wdata,     // Host write data
	input  wire       i_io_wr,        // Host I/O write strobe, one cycle
	input  wire       i_io_rd,        // Host I/O read strobe, one cycle
	input  wire [1:0] i_display_en,   // Display enable field (bit0 LCD, bit1 CRT)
	input  wire       i_vert_int,     // Vertical interrupt status
	input  wire       i_vert_retrace, // Vertical retrace status
	input  wire       i_disp_active,  // Display enable status
	input  wire       i_mem_req,      // Host memory access request, one cycle
	input  wire       i_mem_done,     // Display memory access completes, one cycle
	output reg  [7:0] o_io_rdata,     // Read data, valid cycle after read
	output reg        o_mem_go,       // Memory access start pulse
	output reg        o_ready,        // Host ready, low while access pends
	output reg        o_panel_power_control_n, // Panel power, active low
	output reg        o_seq_running,  // Sequencer running
	output reg        o_char_width9,  // Effective 9-dot width select
	output reg        o_use_alt_clk,  // Alternate pixel clock active
	output reg        o_pri_osc_en,   // Primary oscillator enable
	output reg        o_alt_osc_en    // Alternate oscillator enable
);

	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------
	localparam [3:0] ST_RUN   = 4'b0001;
	localparam [3:0] ST_PWROFF = 4'b0010;
	localparam [3:0] ST_DRAIN = 4'b0100;
	localparam [3:0] ST_HALT  = 4'b1000;

	reg [7:0] misc_r;
	reg [7:0] vse_r;
	reg [2:0] idx_r;
	reg [1:0] seqrst_r;
	reg [7:0] clkmode_r;
	reg [7:0] plane_r;
	reg [7:0] font_r;
	reg [7:0] memmode_r;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [`VMS_CNT_W-1:0] cnt_r;
	reg       busy_r;
	reg       pend_r;
	reg [7:0] rdata_nxt;
	wire      use_alt;
	wire      pri_en;
	wire      alt_en;
	wire      seq_rst_req;
	wire      lcd_only;
	wire      start_now;

	// Full-width cycle count, cut to the counter width on purpose
	localparam [31:0]           PWR_CYC_FULL = `VMS_PWR_OFF_CYC;
	localparam [`VMS_CNT_W-1:0] PWR_CYC      = PWR_CYC_FULL[`VMS_CNT_W-1:0];

	assign seq_rst_req = |seqrst_r;  // [RULE8]
	assign lcd_only    = (i_display_en == `VMS_DEN_LCD_ONLY); // [RULE14]
	assign start_now   = (state_r == ST_RUN) && !busy_r && (pend_r || i_mem_req);

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			misc_r    <= `VMS_ZERO8;
			vse_r     <= `VMS_ZERO8;
			idx_r     <= 3'h0;
			seqrst_r  <= 2'h0;
			clkmode_r <= `VMS_ZERO8;
			plane_r   <= `VMS_PLANE_RST;
			font_r    <= `VMS_ZERO8;
			memmode_r <= `VMS_ZERO8;
		end else if (i_io_wr) begin
			case (i_io_addr)
			`VMS_PORT_MISC_WR: misc_r <= i_io_wdata;   // [RULE2] [RULE3]
			`VMS_PORT_VSE: vse_r <= i_io_wdata & `VMS_VSE_MASK; // [RULE7]
			`VMS_PORT_SEQ_IDX: idx_r <= i_io_wdata[2:0]; // [RULE15]
			`VMS_PORT_SEQ_DATA: begin
				case (idx_r) // [RULE15]
				`VMS_SEQ_RESET: seqrst_r <= i_io_wdata[1:0]; // [RULE8] [RULE16]
				`VMS_SEQ_CLKMODE: clkmode_r <= i_io_wdata & `VMS_CLKMODE_MASK; // [RULE12]
				`VMS_SEQ_PLANEMASK: plane_r <= i_io_wdata & `VMS_PLANE_MASK;
				`VMS_SEQ_FONTMAP: font_r <= i_io_wdata & `VMS_FONTMAP_MASK;
				`VMS_SEQ_MEMMODE: memmode_r <= i_io_wdata & `VMS_MEMMODE_MASK;
				default: ;
				endcase
			end
			default: ; // Revision code and status 1 ports ignore writes; status 0 port writes go to misc output [RULE1]
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	always @* begin
		rdata_nxt = `VMS_ZERO8;
		case (i_io_addr)
		`VMS_PORT_STAT0_RD: rdata_nxt[`VMS_STAT0_VINT_BIT] = i_vert_int; // [RULE6]
		`VMS_PORT_MISC_RD: rdata_nxt = misc_r; // [RULE2]
		`VMS_PORT_VSE: rdata_nxt = vse_r; // [RULE7]
		`VMS_PORT_SEQ_IDX: rdata_nxt = {5'h00, idx_r};
		`VMS_PORT_STAT1_RD: rdata_nxt = {4'h0, i_vert_retrace, 2'h0, i_disp_active};
		`VMS_PORT_REV_RD: rdata_nxt = `VMS_REV_CODE; // [RULE1]
		`VMS_PORT_SEQ_DATA: begin
			case (idx_r)
			`VMS_SEQ_RESET: rdata_nxt = {6'h00, seqrst_r};
			`VMS_SEQ_CLKMODE: rdata_nxt = clkmode_r; // [RULE12]
			`VMS_SEQ_PLANEMASK: rdata_nxt = plane_r;
			`VMS_SEQ_FONTMAP: rdata_nxt = font_r;
			`VMS_SEQ_MEMMODE: rdata_nxt = memmode_r;
			default: rdata_nxt = `VMS_ZERO8;
			endcase
		end
		default: rdata_nxt = `VMS_ZERO8;
		endcase
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			o_io_rdata <= `VMS_ZERO8;
		else if (i_io_rd)
			o_io_rdata <= rdata_nxt;
	end

	// ---------------------------------------------------------------
	// Sequencer reset state machine
	// ---------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_RUN: if (seq_rst_req) state_nxt = ST_PWROFF; // [RULE8]
		ST_PWROFF: if (cnt_r == PWR_CYC) state_nxt = ST_DRAIN; // [RULE9]
		ST_DRAIN: if (!busy_r || i_mem_done) state_nxt = ST_HALT; // [RULE10]
		ST_HALT: if (!seq_rst_req) state_nxt = ST_RUN; // [RULE16]
		default: state_nxt = ST_RUN;
		endcase
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_RUN;
			cnt_r   <= {`VMS_CNT_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_PWROFF)
				cnt_r <= cnt_r + 1'b1;
			else
				cnt_r <= {`VMS_CNT_W{1'b0}};
		end
	end

	// ---------------------------------------------------------------
	// Memory access tracking and ready
	// ---------------------------------------------------------------
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_r   <= 1'b0;
			pend_r   <= 1'b0;
			o_mem_go <= 1'b0;
			o_ready  <= 1'b1;
		end else begin
			o_mem_go <= start_now; // [RULE16]
			if (start_now)
				busy_r <= 1'b1;
			else if (i_mem_done)
				busy_r <= 1'b0; // [RULE10]
			// New request held while not running or busy
			if (start_now)
				pend_r <= 1'b0;
			else if (i_mem_req)
				pend_r <= 1'b1; // [RULE11]
			o_ready <= !(pend_r || (i_mem_req && !start_now)) || start_now; // [RULE11]
		end
	end

	// ---------------------------------------------------------------
	// Panel power, status and effective width
	// ---------------------------------------------------------------
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_panel_power_control_n <= 1'b0;
			o_seq_running           <= 1'b1;
			o_char_width9           <= 1'b0;
		end else begin
			o_panel_power_control_n <= (state_nxt != ST_RUN); // [RULE9]
			o_seq_running           <= (state_nxt != ST_HALT);
			o_char_width9           <= lcd_only ? 1'b0 : clkmode_r[`VMS_CLK_WIDTH_BIT]; // [RULE13]
		end
	end

	// ---------------------------------------------------------------
	// Pixel clock selection
	// ---------------------------------------------------------------
	vms_clock_sel u_clock_sel (
		.i_clock        (i_clock),
		.i_nrst         (i_nrst),
		.i_clock_select (misc_r[`VMS_MISC_CSEL0_BIT+1:`VMS_MISC_CSEL0_BIT]),
		.i_display_en   (i_display_en),
		.o_use_alt      (use_alt),
		.o_pri_osc_en   (pri_en),
		.o_alt_osc_en   (alt_en)
	);

	// Re-register so top outputs come from flops here
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_use_alt_clk <= 1'b0;
			o_pri_osc_en  <= 1'b1;
			o_alt_osc_en  <= 1'b0;
		end else begin
			o_use_alt_clk <= use_alt; // [RULE4]
			o_pri_osc_en  <= pri_en;  // [RULE5]
			o_alt_osc_en  <= alt_en;
		end
	end

endmodule

// file: vms_regs.vh
// Register offsets, field positions and reset values for the misc/sequencer register bank
`ifndef VMS_REGS_VH
`define VMS_REGS_VH

// I/O port addresses (10-bit)
`define VMS_PORT_MISC_WR     10'h3C2
`define VMS_PORT_STAT0_RD    10'h3C2
`define VMS_PORT_VSE         10'h3C3
`define VMS_PORT_SEQ_IDX     10'h3C4
`define VMS_PORT_SEQ_DATA    10'h3C5
`define VMS_PORT_MISC_RD     10'h3CC
`define VMS_PORT_STAT1_RD    10'h3DA
`define VMS_PORT_REV_RD      10'h3D0

// Sequencer indices
`define VMS_SEQ_RESET        3'h0
`define VMS_SEQ_CLKMODE      3'h1
`define VMS_SEQ_PLANEMASK    3'h2
`define VMS_SEQ_FONTMAP      3'h3
`define VMS_SEQ_MEMMODE      3'h4

// Field positions
`define VMS_MISC_STORE_BIT   1
`define VMS_MISC_CSEL0_BIT   2
`define VMS_CLK_WIDTH_BIT    0
`define VMS_VSE_EN_BIT       0
`define VMS_STAT0_VINT_BIT   7
`define VMS_DEN_LCD_BIT      0
`define VMS_DEN_CRT_BIT      1
`define VMS_DEN_LCD_ONLY     2'h1
`define VMS_MEMMODE_MASK     8'h0C
`define VMS_CLKMODE_MASK     8'h3F
`define VMS_FONTMAP_MASK     8'h3F
`define VMS_PLANE_MASK       8'h0F
`define VMS_RESET_MASK       8'h03
`define VMS_IDX_MASK         8'h07
`define VMS_VSE_MASK         8'h01

// Reset values
`define VMS_ZERO8            8'h00
`define VMS_ONES8            8'hFF
`define VMS_PLANE_RST        8'h0F

// Revision code (arbitrary neutral value)
`define VMS_REV_CODE         8'h5A

// Power-down settle time before halt, in ns, and derived cycle count at 50 ns
`define VMS_CLK_PERIOD_NS    50
`define VMS_PWR_OFF_NS       1000
`define VMS_PWR_OFF_CYC      ((`VMS_PWR_OFF_NS + `VMS_CLK_PERIOD_NS - 1) / `VMS_CLK_PERIOD_NS)
`define VMS_CNT_W            6

`endif

// file: vms_clock_sel.v
// Pixel clock source selection and inactive oscillator shutdown
`timescale 1ns/10ps
module vms_clock_sel (
	input  wire       i_clock,        // System clock
	input  wire       i_nrst,         // Async reset, active low
	input  wire [1:0] i_clock_select, // Clock select field
	input  wire [1:0] i_display_en,   // Display enable field
	output reg        o_use_alt,      // 1: alternate clock active
	output reg        o_pri_osc_en,   // Primary oscillator enable
	output reg        o_alt_osc_en    // Alternate oscillator enable
);

	wire use_alt_nxt;

	// LCD-only forces alternate clock, else select bit 0 decides
	assign use_alt_nxt = (i_display_en == `VMS_DEN_LCD_ONLY) ? 1'b1 // [RULE4]
			   : i_clock_select[0];                          // [RULE3]

	// Registered selection; inactive oscillator switched off
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_use_alt    <= 1'b0;
			o_pri_osc_en <= 1'b1;
			o_alt_osc_en <= 1'b0;
		end else begin
			o_use_alt    <= use_alt_nxt;
			o_pri_osc_en <= ~use_alt_nxt; // [RULE5]
			o_alt_osc_en <= use_alt_nxt;  // [RULE5]
		end
	end

endmodule

// file: vms_monitor.sv
// Concurrent checks on the misc/sequencer register bank ports
`timescale 1ns/10ps
`include "vms_regs.vh"
module vms_monitor (
	input wire       i_clock,                 // Clock
	input wire       i_nrst,                  // Reset, active low
	input wire [9:0] i_io_addr,               // I/O address
	input wire       i_io_rd,                 // Read strobe
	input wire [1:0] i_display_en,            // Display enable field
	input wire       i_vert_int,              // Vertical interrupt
	input wire       i_mem_req,               // Memory request
	input wire [7:0] o_io_rdata,              // Read data
	input wire       o_mem_go,                // Access start
	input wire       o_ready,                 // Host ready
	input wire       o_panel_power_control_n, // Panel power
	input wire       o_seq_running,           // Sequencer running
	input wire       o_char_width9,           // 9-dot width
	input wire       o_use_alt_clk,           // Alternate clock
	input wire       o_pri_osc_en,            // Primary osc
	input wire       o_alt_osc_en             // Alternate osc
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// Read decodes
	wire rd_rev = i_io_rd && (i_io_addr == `VMS_PORT_REV_RD);
	wire rd_st0 = i_io_rd && (i_io_addr == `VMS_PORT_STAT0_RD);
	wire lcd1 = (i_display_en == `VMS_DEN_LCD_ONLY);
	// Reset sequence steps
	sequence s_pwr_off;
		$rose(o_panel_power_control_n);
	endsequence
	sequence s_resume;
		$rose(o_seq_running) && !o_ready;
	endsequence
	a_osc_one_hot: assert property (o_pri_osc_en != o_alt_osc_en)
		else $error("oscillator enables not exclusive");
	a_lcd_alt_clk: assert property (lcd1 [*3] |-> o_use_alt_clk)
		else $error("lcd only without alternate clock");
	a_lcd_width_off: assert property (lcd1 [*2] |-> !o_char_width9)
		else $error("width select active in lcd only");
	a_halt_ready_low: assert property (!o_seq_running && i_mem_req |=> !o_ready)
		else $error("ready high for pended access");
	a_halt_no_go: assert property (!o_seq_running |-> !o_mem_go)
		else $error("access started while halted");
	a_halt_panel_off: assert property (!o_seq_running |-> o_panel_power_control_n)
		else $error("halted with panel powered");
	a_pwr_before_halt: assert property (s_pwr_off |-> o_seq_running [*8])
		else $error("halt too soon after power off");
	a_resume_serves: assert property (s_resume |-> ##[0:3] o_mem_go)
		else $error("pending access not served");
	a_rev_read: assert property (rd_rev |=> o_io_rdata == `VMS_REV_CODE)
		else $error("revision code wrong");
	a_stat0_read: assert property (rd_st0 |=> o_io_rdata == {$past(i_vert_int), 7'h00})
		else $error("status zero wrong");
endmodule
bind vms_misc_seq_regs vms_monitor u_mon (.i_clock, .i_nrst, .i_io_addr, .i_io_rd,
	.i_display_en, .i_vert_int, .i_mem_req, .o_io_rdata, .o_mem_go, .o_ready,
	.o_panel_power_control_n, .o_seq_running, .o_char_width9, .o_use_alt_clk,
	.o_pri_osc_en, .o_alt_osc_en);

// file: vms_mem_model.sv
// Display memory responder answering each started access
`timescale 1ns/10ps
module vms_mem_model (
	input  wire       i_clock, // Clock
	input  wire       i_go,    // Access start pulse
	input  wire [5:0] i_lat,   // Cycles to completion
	output reg        o_done   // Completion pulse
);
	integer cnt = 0;
	initial o_done = 1'b0;
	// Count the access down, pulse done at the end
	always @(negedge i_clock) begin
		o_done <= (cnt == 1) && !i_go;
		if (i_go)
			cnt <= i_lat;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule

// file: tb_top.sv
// Self-checking bench for the misc/sequencer register bank
`timescale 1ns/10ps
`include "vms_regs.vh"
module tb_top;
	reg        i_clock = 1'b0, i_nrst = 1'b0, wr = 1'b0, rd = 1'b0, mreq = 1'b0;
	reg        vi = 1'b0, vr = 1'b0, da = 1'b0;
	reg  [9:0] adr = 10'h000;
	reg  [7:0] wd = 8'h00, d, e;
	reg  [1:0] den = 2'h0;
	reg  [5:0] lat = 6'h01;
	wire [7:0] rdat;
	wire       go, rdy, pnl, run, w9, alt, pen, aen, mdone;
	integer    n_errors = 0, checks = 0, nd = 0, i, r, k, n0;
	initial forever #25 i_clock = ~i_clock;
	vms_misc_seq_regs DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_io_addr(adr),
		.i_io_wdata(wd), .i_io_wr(wr), .i_io_rd(rd), .i_display_en(den),
		.i_vert_int(vi), .i_vert_retrace(vr), .i_disp_active(da), .i_mem_req(mreq),
		.i_mem_done(mdone), .o_io_rdata(rdat), .o_mem_go(go), .o_ready(rdy),
		.o_panel_power_control_n(pnl), .o_seq_running(run), .o_char_width9(w9),
		.o_use_alt_clk(alt), .o_pri_osc_en(pen), .o_alt_osc_en(aen));
	vms_mem_model u_mem (.i_clock(i_clock), .i_go(go), .i_lat(lat), .o_done(mdone));
	// Count finished accesses
	always @(posedge i_clock) if (mdone) nd <= nd + 1;
	function ealt(input [7:0] m, input [1:0] de);
		ealt = (de == `VMS_DEN_LCD_ONLY) | m[`VMS_MISC_CSEL0_BIT];
	endfunction
	task test_done;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wrp(input [9:0] a, input [7:0] v);
		@(negedge i_clock); adr = a; wd = v; wr = 1'b1;
		@(negedge i_clock); wr = 1'b0;
	endtask
	task rdc(input [9:0] a, input [7:0] m, input [7:0] x);
		@(negedge i_clock); adr = a; rd = 1'b1;
		@(negedge i_clock); rd = 0; chk(rdat & m, x);
	endtask
	task wt(input v);
		k = 0;
		while (((v ? rdy : run) !== v) && k < 300) begin @(negedge i_clock); k = k + 1; end
		if (k == 300) begin n_errors = n_errors + 1; test_done; end
	endtask
	initial begin
		void'($urandom(52558));
		repeat (2) @(negedge i_clock);
		i_nrst = 1'b1;
		rdc(`VMS_PORT_MISC_RD, 8'hFF, 8'h00);
		wrp(`VMS_PORT_SEQ_IDX, 8'h02); rdc(`VMS_PORT_SEQ_DATA, 8'hFF, 8'h0F);
		wrp(`VMS_PORT_REV_RD, 8'($urandom)); rdc(`VMS_PORT_REV_RD, 8'hFF, 8'h5A);
		$display("test reset_and_revision done");
		for (i = 0; i < 16; i = i + 1) begin
			d = 8'($urandom); e = 8'($urandom); den = i[1:0]; {vi, vr, da} = e[2:0];
			wrp(`VMS_PORT_MISC_WR, d); rdc(`VMS_PORT_MISC_RD, 8'hFF, d);
			repeat (3) @(negedge i_clock);
			chk(alt, ealt(d, den));
			chk({pen, aen}, {!ealt(d, den), ealt(d, den)});
			wrp(`VMS_PORT_SEQ_IDX, 8'h01); wrp(`VMS_PORT_SEQ_DATA, d);
			rdc(`VMS_PORT_SEQ_DATA, 8'hFF, d & 8'h3F);
			chk(w9, d[0] && den != `VMS_DEN_LCD_ONLY);
			rdc(`VMS_PORT_STAT0_RD, 8'hFF, {vi, 7'h00});
			rdc(`VMS_PORT_STAT1_RD, 8'hFF, {4'h0, vr, 2'h0, da});
			wrp(`VMS_PORT_VSE, e); rdc(`VMS_PORT_VSE, 8'hFF, e & 8'h01);
		end
		$display("test random_registers done");
		for (r = 1; r < 4; r = r + 1) begin
			lat = 6'd30; n0 = nd;
			@(negedge i_clock); mreq = 1'b1;
			@(negedge i_clock); mreq = 1'b0;
			wrp(`VMS_PORT_SEQ_IDX, 8'h00); wrp(`VMS_PORT_SEQ_DATA, r[7:0]);
			@(negedge i_clock); chk(pnl, 1'b1);
			wt(1'b0); chk(nd - n0, 1);
			lat = 6'(1 + $urandom % 8);
			@(negedge i_clock); mreq = 1'b1;
			@(negedge i_clock); mreq = 1'b0;
			@(negedge i_clock); chk(rdy, 1'b0);
			rdc(`VMS_PORT_SEQ_DATA, 8'h03, r[7:0]); chk(run, 1'b0);
			wrp(`VMS_PORT_SEQ_DATA, 8'h00); wt(1'b1); chk({pnl, run}, 2'b01);
			repeat (12) @(negedge i_clock); chk(nd - n0, 2);
		end
		$display("test sequencer_reset done");
		test_done;
	end
endmodule
